// *** hdl/mcp_protect.sv ***
// undercurrent, unbalance, phase reversal and start-up supervision decisions
`default_nettype none
module mcp_protect
#(
    parameter int TICK_CYCLES = mcp_pkg::TICK_CYCLES
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // fundamental currents, secondary mA
    input wire logic [15:0] phase_a_ma,
    input wire logic [15:0] phase_b_ma,
    input wire logic [15:0] phase_c_ma,
    input wire logic [15:0] pos_seq_ma,
    input wire logic [15:0] neg_seq_ma,
    // motor settings
    input wire logic [15:0] motor_nominal_current,
    input wire logic [9:0] start_detection_level,
    input wire logic [9:0] rated_start_current_in,
    input wire logic rated_start_current_wr,
    input wire logic [1:0] group_sel,
    // undercurrent settings per group, percent and ms
    input wire logic [3:0][9:0] uc_level_pct,
    input wire logic [3:0][19:0] uc_delay_ms,
    // unbalance settings per group
    input wire logic [3:0][9:0] unbalance_start_setting,
    input wire logic [3:0] definite_time_mode,
    input wire logic [3:0][19:0] nps_delay_ms,
    input wire logic [3:0][5:0] delay_multiplier,
    // start-up supervision settings
    input wire logic st_definite_time_mode,
    input wire logic [19:0] st_delay_ms,
    input wire logic [19:0] max_allowed_start_time,
    // stage outputs
    output logic uc_start,
    output logic uc_trip,
    output logic unbalance_start,
    output logic unbalance_trip,
    output logic reversal_start,
    output logic reversal_trip,
    output logic startup_start,
    output logic startup_trip,
    // motor condition
    output logic motor_starting,
    output logic motor_running,
    output logic [9:0] rated_start_current
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // x above pct percent of nominal, scaled by n (n=3 for phase sums)
    function automatic logic above(input logic [17:0] x, input logic [9:0] pct, input logic [1:0] n);
        above = (32'(x) * 32'(mcp_pkg::PCT_SCALE)) > (32'(pct) * 32'(motor_nominal_current) * 32'(n));
    endfunction

    function automatic logic [9:0] p10(input int v);
        p10 = v[9:0];
    endfunction

    logic tick;
    logic [16:0] tick_cnt_q;
    logic [17:0] sum3;
    logic [15:0] max_ph;
    logic [15:0] min_ph;
    logic all_above_min;
    mcp_pkg::mcp_motor_t state_q;

    assign sum3 = 18'(phase_a_ma) + 18'(phase_b_ma) + 18'(phase_c_ma);
    assign max_ph = (phase_a_ma > phase_b_ma) ? ((phase_a_ma > phase_c_ma) ? phase_a_ma : phase_c_ma)
                                              : ((phase_b_ma > phase_c_ma) ? phase_b_ma : phase_c_ma);
    assign min_ph = (phase_a_ma < phase_b_ma) ? ((phase_a_ma < phase_c_ma) ? phase_a_ma : phase_c_ma)
                                              : ((phase_b_ma < phase_c_ma) ? phase_b_ma : phase_c_ma);
    assign all_above_min = min_ph > 16'(mcp_pkg::NPS_MIN_MA);

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || tick_cnt_q == 17'(TICK_CYCLES - 1))
            tick_cnt_q <= 17'h0;
        else
            tick_cnt_q <= tick_cnt_q + 17'h1;
    end
    assign tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));

    mcp_timer_if uc_t ();
    mcp_timer_if nps_t ();
    mcp_timer_if cap_t ();
    mcp_timer_if prv_t ();
    mcp_timer_if run_t ();
    mcp_timer_if raise_t ();
    mcp_timer_if st_t ();
    mcp_timer u_uc (.core_clk(core_clk), .rst_n(rst_n), .t(uc_t));
    mcp_timer u_nps (.core_clk(core_clk), .rst_n(rst_n), .t(nps_t));
    mcp_timer u_cap (.core_clk(core_clk), .rst_n(rst_n), .t(cap_t));
    mcp_timer u_prv (.core_clk(core_clk), .rst_n(rst_n), .t(prv_t));
    mcp_timer u_run (.core_clk(core_clk), .rst_n(rst_n), .t(run_t));
    mcp_timer u_raise (.core_clk(core_clk), .rst_n(rst_n), .t(raise_t));
    mcp_timer u_st (.core_clk(core_clk), .rst_n(rst_n), .t(st_t));
    assign uc_t.tick = tick;
    assign nps_t.tick = tick;
    assign cap_t.tick = tick;
    assign prv_t.tick = tick;
    assign run_t.tick = tick;
    assign raise_t.tick = tick;
    assign st_t.tick = tick;

    // ------------------------------------------------------------
    // phase undercurrent
    // ------------------------------------------------------------
    logic uc_block;
    logic uc_cond;
    assign uc_block = !above(18'(max_ph), p10(mcp_pkg::UC_BLOCK_PCT), 2'd1);
    assign uc_cond = !uc_block && !above(18'(min_ph), uc_level_pct[group_sel], 2'd1);
    assign uc_t.en = uc_cond;
    assign uc_t.limit = 32'(uc_delay_ms[group_sel]);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            uc_start <= 1'b0;
            uc_trip <= 1'b0;
        end
        else
        begin
            uc_start <= uc_cond;
            uc_trip <= uc_cond && uc_t.done;
        end
    end

    // ------------------------------------------------------------
    // negative sequence overcurrent
    // ------------------------------------------------------------
    localparam int ACC_W_L = mcp_pkg::ACC_W;
    logic nps_cond;
    logic [ACC_W_L-1:0] nps_acc_q;
    logic [ACC_W_L-1:0] nps_inc;
    logic [ACC_W_L-1:0] nps_limit;
    logic nps_inv_done;
    assign nps_cond = all_above_min && above(18'(neg_seq_ma), unbalance_start_setting[group_sel], 2'd1);
    // integrate squared excess so no divider is needed
    assign nps_inc = ACC_W_L'(neg_seq_ma) * ACC_W_L'(neg_seq_ma) * ACC_W_L'(mcp_pkg::PCT_SQ_SCALE)
                   - ACC_W_L'(unbalance_start_setting[group_sel]) * ACC_W_L'(unbalance_start_setting[group_sel])
                   * ACC_W_L'(motor_nominal_current) * ACC_W_L'(motor_nominal_current);
    assign nps_limit = ACC_W_L'(delay_multiplier[group_sel]) * ACC_W_L'(mcp_pkg::MS_PER_S)
                     * ACC_W_L'(motor_nominal_current) * ACC_W_L'(motor_nominal_current)
                     * ACC_W_L'(mcp_pkg::PCT_SQ_SCALE);
    // strict compare: the first tick may be partial, so never trip early
    assign nps_inv_done = nps_acc_q > nps_limit;
    assign nps_t.en = nps_cond;
    assign nps_t.limit = 32'(nps_delay_ms[group_sel]);
    assign cap_t.en = nps_cond;
    assign cap_t.limit = 32'(mcp_pkg::NPS_CAP_MS);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !nps_cond)
            nps_acc_q <= '0;
        else if (tick && !nps_inv_done)
            nps_acc_q <= nps_acc_q + nps_inc;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            unbalance_start <= 1'b0;
            unbalance_trip <= 1'b0;
        end
        else
        begin
            unbalance_start <= nps_cond;
            unbalance_trip <= nps_cond && (definite_time_mode[group_sel] ? nps_t.done
                                                                         : (nps_inv_done || cap_t.done));
        end
    end

    // ------------------------------------------------------------
    // motor condition
    // ------------------------------------------------------------
    logic avg_stopped;
    logic avg_run_low;
    logic avg_run_high;
    logic avg_start_det;
    assign avg_stopped = !above(sum3, p10(mcp_pkg::STOP_PCT), 2'd3);
    assign avg_run_low = above(sum3, p10(mcp_pkg::RUN_LOW_PCT), 2'd3);
    assign avg_run_high = above(sum3, p10(mcp_pkg::RUN_HIGH_PCT), 2'd3);
    assign avg_start_det = above(sum3, start_detection_level, 2'd3);
    // rise window starts when current leaves the stopped band
    assign raise_t.en = (state_q == mcp_pkg::MOTOR_STOPPED) && !avg_stopped;
    assign raise_t.limit = 32'(mcp_pkg::RAISE_MS);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            state_q <= mcp_pkg::MOTOR_STOPPED;
        else
        begin
            unique case (state_q)
                mcp_pkg::MOTOR_STOPPED:
                begin
                    if (avg_start_det && !raise_t.done)
                        state_q <= mcp_pkg::MOTOR_STARTING;
                    // soft start goes straight to running
                    else if (avg_run_low && !avg_run_high)
                        state_q <= mcp_pkg::MOTOR_RUNNING;
                end
                mcp_pkg::MOTOR_STARTING:
                begin
                    if (avg_stopped)
                        state_q <= mcp_pkg::MOTOR_STOPPED;
                    else if (!avg_run_high)
                        state_q <= mcp_pkg::MOTOR_RUNNING;
                end
                mcp_pkg::MOTOR_RUNNING:
                begin
                    if (avg_stopped)
                        state_q <= mcp_pkg::MOTOR_STOPPED;
                end
                default:
                    state_q <= mcp_pkg::MOTOR_STOPPED;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            motor_starting <= 1'b0;
            motor_running <= 1'b0;
        end
        else
        begin
            motor_starting <= state_q == mcp_pkg::MOTOR_STARTING;
            motor_running <= state_q == mcp_pkg::MOTOR_RUNNING;
        end
    end

    // ------------------------------------------------------------
    // incorrect phase sequence
    // ------------------------------------------------------------
    logic prv_cond;
    assign run_t.en = state_q == mcp_pkg::MOTOR_RUNNING;
    assign run_t.limit = 32'(mcp_pkg::RUN_BLOCK_MS);
    // ratio, average and single-phase floor; single fixed setting
    assign prv_cond = !run_t.done
                   && (32'(neg_seq_ma) * 32'(mcp_pkg::PCT_SCALE) > 32'(pos_seq_ma) * 32'(mcp_pkg::PRV_RATIO_PCT))
                   && above(sum3, p10(mcp_pkg::PRV_MIN_PCT), 2'd3)
                   && above(18'(max_ph), p10(mcp_pkg::PRV_MIN_PCT), 2'd1);
    assign prv_t.en = prv_cond;
    assign prv_t.limit = 32'(mcp_pkg::PRV_DELAY_MS);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reversal_start <= 1'b0;
            reversal_trip <= 1'b0;
        end
        else
        begin
            reversal_start <= prv_cond;
            reversal_trip <= prv_cond && prv_t.done;
        end
    end

    // ------------------------------------------------------------
    // start-up supervision
    // ------------------------------------------------------------
    logic st_active;
    logic [ACC_W_L-1:0] st_acc_q;
    logic [ACC_W_L-1:0] st_limit;
    logic st_inv_done;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rated_start_current <= mcp_pkg::RATED_START_RST;
        else if (rated_start_current_wr)
            rated_start_current <= rated_start_current_in;
    end
    assign st_active = state_q == mcp_pkg::MOTOR_STARTING;
    assign st_t.en = st_active;
    assign st_t.limit = 32'(st_delay_ms);
    // integrate measured squared current against rated squared times start time
    assign st_limit = ACC_W_L'(rated_start_current) * ACC_W_L'(rated_start_current)
                    * ACC_W_L'(motor_nominal_current) * ACC_W_L'(motor_nominal_current)
                    * ACC_W_L'(max_allowed_start_time);
    assign st_inv_done = st_acc_q > st_limit;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !st_active)
            st_acc_q <= '0;
        else if (tick && !st_inv_done)
            st_acc_q <= st_acc_q + ACC_W_L'(max_ph) * ACC_W_L'(max_ph) * ACC_W_L'(mcp_pkg::PCT_SQ_SCALE);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            startup_start <= 1'b0;
            startup_trip <= 1'b0;
        end
        else
        begin
            startup_start <= st_active;
            startup_trip <= st_active && (st_definite_time_mode ? st_t.done : st_inv_done);
        end
    end
endmodule
`default_nettype wire

// *** hdl/mcp_pkg.sv ***
// constants shared by the motor current protection stages
`default_nettype none
package mcp_pkg;
    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;
    localparam int PCT_SCALE = 100;
    localparam int PCT_SQ_SCALE = PCT_SCALE * PCT_SCALE;
    // ------------------------------------------------------------
    // fixed limits
    // ------------------------------------------------------------
    localparam int UC_BLOCK_PCT = 15;
    localparam int NPS_MIN_MA = 250;
    localparam int NPS_CAP_MS = 1000000;
    localparam int PRV_RATIO_PCT = 80;
    localparam int PRV_MIN_PCT = 20;
    localparam int PRV_DELAY_MS = 100;
    localparam int RUN_BLOCK_MS = 2000;
    localparam int STOP_PCT = 10;
    localparam int RUN_LOW_PCT = 20;
    localparam int RUN_HIGH_PCT = 120;
    localparam int RAISE_MS = 200;
    localparam logic [9:0] RATED_START_RST = 10'h258;
    localparam int NUM_GROUPS = 4;
    localparam int ACC_W = 72;
    // ------------------------------------------------------------
    // motor condition
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MOTOR_STOPPED = 2'b00,
        MOTOR_STARTING = 2'b01,
        MOTOR_RUNNING = 2'b10
    } mcp_motor_t;
endpackage
`default_nettype wire

// *** hdl/mcp_timer_if.sv ***
// millisecond timer request and answer
`default_nettype none
interface mcp_timer_if;
    logic tick;
    logic en;
    logic [31:0] limit;
    logic done;
    modport ctrl (output tick, output en, output limit, input done);
    modport timer (input tick, input en, input limit, output done);
endinterface
`default_nettype wire

// *** hdl/mcp_timer.sv ***
// millisecond delay timer, restarts whenever its enable drops
`default_nettype none
module mcp_timer
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request
    mcp_timer_if.timer t
);
    logic [31:0] cnt_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !t.en)
            cnt_q <= 32'h0;
        else if (t.tick && cnt_q != 32'hFFFFFFFF)
            cnt_q <= cnt_q + 32'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !t.en)
            t.done <= 1'b0;
        else
            // first tick may land one cycle in: count one past the limit so a trip is never early
            t.done <= (cnt_q > t.limit);
    end
endmodule
`default_nettype wire

// *** tb/mcp_meter.sv ***
// behavioural measurement front end: phase magnitudes and sequence currents
`default_nettype none
module mcp_meter
(
    // requested magnitudes, mA
    input wire logic [15:0] set_a,
    input wire logic [15:0] set_b,
    input wire logic [15:0] set_c,
    input wire logic [15:0] set_neg,
    // fundamental quantities
    output logic [15:0] phase_a_ma,
    output logic [15:0] phase_b_ma,
    output logic [15:0] phase_c_ma,
    output logic [15:0] pos_seq_ma,
    output logic [15:0] neg_seq_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] sum;
    assign phase_a_ma = set_a;
    assign phase_b_ma = set_b;
    assign phase_c_ma = set_c;
    assign sum = 18'(set_a) + 18'(set_b) + 18'(set_c);
    // average as positive sequence: exact only for balanced magnitudes
    assign pos_seq_ma = 16'(sum / 18'h3);
    assign neg_seq_ma = set_neg;
endmodule
`default_nettype wire

// *** tb/mcp_protect_monitor.sv ***
// assertion checker on the protection block ports
`default_nettype none
module mcp_protect_monitor
#(
    parameter int TICK_CYCLES = 100000
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // currents and settings
    input wire logic [15:0] phase_a_ma,
    input wire logic [15:0] phase_b_ma,
    input wire logic [15:0] phase_c_ma,
    input wire logic [15:0] motor_nominal_current,
    input wire logic [9:0] rated_start_current_in,
    input wire logic rated_start_current_wr,
    // stage outputs
    input wire logic uc_start,
    input wire logic uc_trip,
    input wire logic unbalance_start,
    input wire logic unbalance_trip,
    input wire logic reversal_start,
    input wire logic reversal_trip,
    input wire logic startup_start,
    input wire logic motor_starting,
    input wire logic motor_running,
    input wire logic [9:0] rated_start_current
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REV_LO = mcp_pkg::PRV_DELAY_MS * TICK_CYCLES;
    localparam int REV_HI = (mcp_pkg::PRV_DELAY_MS + 2) * TICK_CYCLES + 4;
    logic [15:0] mx_ab, mn_ab;
    logic [31:0] mx, mn, sm, pn, rev_cnt_q;
    logic blk_q, inh_q, low_q;
    logic [1:0] rel_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // input conditions, delayed to line up with the outputs
    // ------------------------------------------------------------
    assign mx_ab = phase_a_ma > phase_b_ma ? phase_a_ma : phase_b_ma;
    assign mn_ab = phase_a_ma < phase_b_ma ? phase_a_ma : phase_b_ma;
    assign mx = 32'(mx_ab > phase_c_ma ? mx_ab : phase_c_ma);
    assign mn = 32'(mn_ab < phase_c_ma ? mn_ab : phase_c_ma);
    assign sm = 32'(phase_a_ma) + 32'(phase_b_ma) + 32'(phase_c_ma);
    assign pn = 32'(motor_nominal_current);
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            {blk_q, inh_q, low_q, rel_q} <= '0;
            rev_cnt_q <= '0;
        end
        else
        begin
            blk_q <= (mx * mcp_pkg::PCT_SCALE <= mcp_pkg::UC_BLOCK_PCT * pn);
            inh_q <= (mn <= mcp_pkg::NPS_MIN_MA);
            low_q <= (mx * mcp_pkg::PCT_SCALE <= mcp_pkg::PRV_MIN_PCT * pn);
            // state then output: two stages of lag
            rel_q <= {rel_q[0], (sm * mcp_pkg::PCT_SCALE <= 32'h3 * mcp_pkg::RUN_HIGH_PCT * pn)};
            rev_cnt_q <= reversal_start ? rev_cnt_q + 32'h1 : 32'h0;
        end
    end
    AST_UC_BLOCK: assert property (blk_q |-> !uc_start)
        else $error("undercurrent start while all phases under block limit");
    AST_UC_TRIP: assert property ($rose(uc_trip) |-> uc_start)
        else $error("undercurrent trip without start");
    AST_NPS_INHIBIT: assert property (inh_q |-> !unbalance_start)
        else $error("unbalance start with a phase at or under minimum");
    AST_NPS_TRIP: assert property ($rose(unbalance_trip) |-> unbalance_start)
        else $error("unbalance trip without start");
    AST_REV_LOW: assert property (low_q |-> !reversal_start)
        else $error("reversal start with no phase above minimum");
    AST_REV_TIME: assert property ($rose(reversal_trip) |-> rev_cnt_q >= REV_LO && rev_cnt_q <= REV_HI)
        else $error("reversal trip outside its delay");
    AST_REV_LATE: assert property (reversal_start && !reversal_trip |-> rev_cnt_q <= REV_HI)
        else $error("reversal trip overdue");
    AST_RATED_RST: assert property (!$past(rst_n) |-> rated_start_current == mcp_pkg::RATED_START_RST)
        else $error("rated start current not at default after reset");
    AST_RATED_WR: assert property (rated_start_current_wr |=> rated_start_current == $past(rated_start_current_in))
        else $error("rated start current not loaded");
    AST_SUPV_STATE: assert property (startup_start |-> motor_starting && !motor_running)
        else $error("supervision start outside starting state");
    AST_SUPV_RELEASE: assert property (rel_q[1] |-> !startup_start)
        else $error("supervision not released under running limit");
endmodule
bind mcp_protect mcp_protect_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mcp_protect_monitor (.core_clk(core_clk),
    .rst_n(rst_n), .phase_a_ma(phase_a_ma), .phase_b_ma(phase_b_ma), .phase_c_ma(phase_c_ma),
    .motor_nominal_current(motor_nominal_current), .rated_start_current_in(rated_start_current_in),
    .rated_start_current_wr(rated_start_current_wr), .uc_start(uc_start), .uc_trip(uc_trip),
    .unbalance_start(unbalance_start), .unbalance_trip(unbalance_trip), .reversal_start(reversal_start),
    .reversal_trip(reversal_trip), .startup_start(startup_start), .motor_starting(motor_starting),
    .motor_running(motor_running), .rated_start_current(rated_start_current));
`default_nettype wire

// *** tb/mcp_protect_tb.sv ***
// self-checking bench for the motor current protection stages
`default_nettype none
module mcp_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rs_wr = 1'b0;
    logic st_dt = 1'b1;
    logic [1:0] grp = 2'h0;
    logic [15:0] set_a = 16'h0, set_b = 16'h0, set_c = 16'h0, set_neg = 16'h0;
    logic [15:0] ph_a, ph_b, ph_c, pos_seq, neg_seq;
    logic [9:0] rs_in = 10'h0, rated;
    logic [3:0][9:0] uc_lvl = {10'h01E, 10'h032, 10'h01E, 10'h01E};
    logic [3:0][19:0] uc_dly = {4{20'h00003}}, nps_dly = {4{20'h00002}};
    logic [3:0][9:0] k2 = {4{10'h00A}};
    logic [3:0][5:0] k1 = {4{6'h01}};
    logic [3:0] dt = 4'h7;
    logic uc_s, uc_t, nb_s, nb_t, rv_s, rv_t, su_s, su_t, m_st, m_run;
    logic [3:0] trips;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n = 0;
    assign trips = {su_t, rv_t, nb_t, uc_t};
    always #5 core_clk = ~core_clk;
    mcp_meter u_mcp_meter (.set_a(set_a), .set_b(set_b), .set_c(set_c), .set_neg(set_neg), .phase_a_ma(ph_a),
        .phase_b_ma(ph_b), .phase_c_ma(ph_c), .pos_seq_ma(pos_seq), .neg_seq_ma(neg_seq));
    mcp_protect #(.TICK_CYCLES(T)) u_mcp_protect (.core_clk(core_clk), .rst_n(rst_n), .phase_a_ma(ph_a),
        .phase_b_ma(ph_b), .phase_c_ma(ph_c), .pos_seq_ma(pos_seq), .neg_seq_ma(neg_seq),
        .motor_nominal_current(16'h03E8), .start_detection_level(10'h12C), .rated_start_current_in(rs_in),
        .rated_start_current_wr(rs_wr), .group_sel(grp), .uc_level_pct(uc_lvl), .uc_delay_ms(uc_dly),
        .unbalance_start_setting(k2), .definite_time_mode(dt), .nps_delay_ms(nps_dly), .delay_multiplier(k1),
        .st_definite_time_mode(st_dt), .st_delay_ms(20'h00005), .max_allowed_start_time(20'h0000A),
        .uc_start(uc_s), .uc_trip(uc_t), .unbalance_start(nb_s), .unbalance_trip(nb_t), .reversal_start(rv_s),
        .reversal_trip(rv_t), .startup_start(su_s), .startup_trip(su_t), .motor_starting(m_st),
        .motor_running(m_run), .rated_start_current(rated));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t ns: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic span(input int lo, input int hi);
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // all inputs move on the falling edge
    task automatic drive(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] g);
        @(negedge core_clk);
        set_a = a;
        set_b = b;
        set_c = c;
        set_neg = g;
    endtask
    task automatic wait_trip(input int idx, input int lim);
        n = 0;
        while (trips[idx] !== 1'b1 && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        idle(2);
        rst_n = 1'b1;
        check(rated, 10'h258);
        rs_in = 10'h1F4;
        rs_wr = 1'b1;
        idle(1);
        rs_wr = 1'b0;
        check(rated, 10'h1F4);
        // reversal needs one phase over 20 percent
        drive(16'h0096, 16'h0096, 16'h0096, 16'h0096);
        idle(5);
        check(rv_s, 1'b0);
        // reversal at start, blocked after 2 s running
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h0384);
        wait_trip(2, 1300);
        check(m_run, 1'b1);
        check(rv_s, 1'b1);
        span(99 * T, 102 * T + 5);
        idle(2000 * T);
        check(rv_s, 1'b0);
        // undercurrent per group, then block limit
        drive(16'h0190, 16'h0190, 16'h0190, 16'h0000);
        idle(10);
        check(uc_s, 1'b0);
        grp = 2'h2;
        wait_trip(0, 200);
        check(uc_s, 1'b1);
        span(3 * T, 5 * T + 5);
        drive(16'h0064, 16'h0064, 16'h0064, 16'h0000);
        idle(3);
        check({uc_s, uc_t}, 2'h0);
        // unbalance definite, setting edge, phase minimum
        grp = 2'h1;
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h00C8);
        wait_trip(1, 200);
        check(nb_s, 1'b1);
        span(2 * T, 4 * T + 5);
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h0064);
        idle(3);
        check(nb_s, 1'b0);
        drive(16'h03E8, 16'h03E8, 16'h00FA, 16'h00C8);
        idle(3);
        check(nb_s, 1'b0);
        drive(16'h03E8, 16'h03E8, 16'h00FB, 16'h00C8);
        idle(3);
        check(nb_s, 1'b1);
        // dependent unbalance: 1 s over 0.99 gives about 1010 ms
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h0000);
        grp = 2'h3;
        idle(3);
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8);
        wait_trip(1, 12000);
        span(1000 * T, 1030 * T);
        // start-up supervision, definite then dependent
        drive(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        idle(3);
        drive(16'h1388, 16'h1388, 16'h1388, 16'h0000);
        wait_trip(3, 200);
        check({m_st, su_s}, 2'h3);
        span(5 * T, 7 * T + 6);
        drive(16'h03E8, 16'h03E8, 16'h03E8, 16'h0000);
        idle(3);
        check({su_s, su_t, m_run}, 3'h1);
        st_dt = 1'b0;
        drive(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        idle(3);
        drive(16'h1388, 16'h1388, 16'h1388, 16'h0000);
        wait_trip(3, 300);
        span(10 * T, 12 * T + 6);
        // no start from running, even above the detection level
        drive(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        idle(3);
        drive(16'h01F4, 16'h01F4, 16'h01F4, 16'h0000);
        idle(3);
        drive(16'h1388, 16'h1388, 16'h1388, 16'h0000);
        idle(5);
        check({m_st, su_s}, 2'h0);
        // slow rise past the raise window: no start
        drive(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        idle(3);
        drive(16'h0096, 16'h0096, 16'h0096, 16'h0000);
        idle(2100);
        drive(16'h1388, 16'h1388, 16'h1388, 16'h0000);
        idle(5);
        check({m_st, su_s, m_run}, 3'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
